// ==== spc_pkg.sv ====
// Shared constants: register map, resets, timing.
// Assumes a 100 MHz clock and a classic Wishbone slave port with 32-bit data.
// What this block does
// [R1] Direction setting keeps or reverses pulse count
// [R2] Edge setting picks rising or falling count
// [R3] Pulse filter width is setting times 0.1us
// [R4] Done condition modes 0, 1, 2 selectable
// [R5] Done window threshold 0-65535 command units
// [R6] Separate window drives the proximity output
// [R7] Pulses per rev; zero selects gear pair
// [R8] Deviation over limit raises alarm E.501
// [R9] Moving-average smoothing, 0.1 ms steps
// [R10] Low-pass smoothing, 0.1 ms steps
// [R11] Divided count: times 4, or 2^23 ratio
// [R12] A and B emit configured pulses per rev
// [R13] Phase setting reverses divided A/B order
// [R14] Warning A.900 at percent of alarm limit
// [R15] Servo-on deviation over limit raises E.503
// [R16] Warning A.901 at percent of servo-on limit
// [R17] Overshoot threshold is percent of done window
// [R18] Quadrature, pulse+direction or CW/CCW inputs
// [R19] Overtravel optionally clears residual deviation
// [R20] Deviation is signed scaled command minus feedback
// [R21] Two gear pairs, picked by select input
package spc_pkg;
   // Timing
   localparam int CLK_PERIOD_PS = 10000;
   localparam int FILT_UNIT_PS = 100000;
   localparam int FILT_UNIT_CYC = (FILT_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SMOOTH_UNIT_PS = 100000000;
   localparam int SMOOTH_UNIT_CYC = SMOOTH_UNIT_PS / CLK_PERIOD_PS;
   localparam int ENC_LOG2 = 23;
   localparam logic [31:0] ENC_COUNTS = 32'h0080_0000;
   // Register indices; byte offset is index times four
   localparam logic [4:0] IDX_CTRL = 5'h00;
   localparam logic [4:0] IDX_FILT = 5'h01;
   localparam logic [4:0] IDX_DONE_WIN = 5'h02;
   localparam logic [4:0] IDX_NEAR_WIN = 5'h03;
   localparam logic [4:0] IDX_PPR = 5'h04;
   localparam logic [4:0] IDX_DEV_LIM = 5'h05;
   localparam logic [4:0] IDX_MAVG = 5'h06;
   localparam logic [4:0] IDX_LPF = 5'h07;
   localparam logic [4:0] IDX_DIV_DEN = 5'h08;
   localparam logic [4:0] IDX_DIV_CNT = 5'h09;
   localparam logic [4:0] IDX_WARN_PCT = 5'h0a;
   localparam logic [4:0] IDX_SON_LIM = 5'h0b;
   localparam logic [4:0] IDX_SON_PCT = 5'h0c;
   localparam logic [4:0] IDX_OVS_PCT = 5'h0d;
   localparam logic [4:0] IDX_G1N = 5'h0e;
   localparam logic [4:0] IDX_G1D = 5'h0f;
   localparam logic [4:0] IDX_G2N = 5'h10;
   localparam logic [4:0] IDX_G2D = 5'h11;
   localparam logic [4:0] IDX_STATUS = 5'h12;
   localparam logic [4:0] IDX_DEV = 5'h13;
   localparam int NCFG = 18;
   // Writable width masks and reset values, by index
   localparam logic [31:0] CFG_MASK [NCFG] = '{
      32'h0000_01ff, 32'h0000_07ff, 32'h0000_ffff, 32'h0000_ffff,
      32'h3fff_ffff, 32'h3fff_ffff, 32'h0000_3fff, 32'h0000_ffff,
      32'h3fff_ffff, 32'h0000_ffff, 32'h0000_007f, 32'h3fff_ffff,
      32'h0000_007f, 32'h0000_007f, 32'h3fff_ffff, 32'h3fff_ffff,
      32'h3fff_ffff, 32'h3fff_ffff};
   localparam logic [31:0] CFG_RST [NCFG] = '{
      32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h1, 32'h1, 32'h1, 32'h1};
   // Control register fields
   localparam int CTL_FMT_LSB = 0;
   localparam int CTL_OT_CLR = 2;
   localparam int CTL_DIR_INV = 3;
   localparam int CTL_FALL = 4;
   localparam int CTL_DONE_LSB = 5;
   localparam int CTL_PH_INV = 7;
   localparam int CTL_GEAR_SW = 8;
   // Status bits
   localparam int ST_DONE = 0;
   localparam int ST_NEAR = 1;
   localparam int ST_ALM_DEV = 2;
   localparam int ST_ALM_SON = 3;
   localparam int ST_WRN_DEV = 4;
   localparam int ST_WRN_SON = 5;
   localparam int ST_OVS = 6;
   // Input formats and done modes
   localparam logic [1:0] FMT_QUAD = 2'h0;
   localparam logic [1:0] FMT_PDIR = 2'h1;
   localparam logic [1:0] DONE_DEV = 2'h0;
   localparam logic [1:0] DONE_FILT = 2'h1;
   localparam logic [1:0] DONE_POST = 2'h2;
endpackage

// ==== spc_cmd_in.sv ====
// Command pulse input: synchroniser, glitch filter and format decode.
// Assumes pa_i/pb_i are raw pins; config comes from the same clock.
`timescale 1ns/10ps
module spc_cmd_in
   import spc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pins
   input wire logic pa_i,
   input wire logic pb_i,
   // Settings
   input wire logic [1:0] fmt_i,
   input wire logic fall_i,
   input wire logic inv_i,
   input wire logic [10:0] width_i,
   // Decoded step
   output logic step_o,
   output logic up_o
);
   logic [1:0] s1, s2, f, p;
   logic [14:0] lim;
   logic a_e, b_e, nstep, nup;
   assign lim = 15'(width_i * FILT_UNIT_CYC); // [R3]
   // Two-flop synchroniser for both pins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1 <= 2'h0;
         s2 <= 2'h0;
      end
      else
      begin
         s1 <= {pb_i, pa_i};
         s2 <= s1;
      end
   end
   // Level must hold the full width to pass
   for (genvar i = 0; i < 2; i++)
   begin : g_filt
      logic [14:0] cnt;
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
         begin
            cnt <= 15'h0;
            f[i] <= 1'b0;
         end
         else if (s2[i] == f[i])
            cnt <= 15'h0;
         else if (cnt >= lim)
         begin
            f[i] <= s2[i]; // [R3]
            cnt <= 15'h0;
         end
         else
            cnt <= cnt + 15'h1;
      end
   end
   // Edge per channel, polarity chosen by setting
   assign a_e = fall_i ? (p[0] & ~f[0]) : (f[0] & ~p[0]); // [R2]
   assign b_e = fall_i ? (p[1] & ~f[1]) : (f[1] & ~p[1]); // [R2]
   // Format decode
   always_comb
   begin
      nstep = 1'b0;
      nup = 1'b0;
      case (fmt_i)
         FMT_QUAD:
         begin
            nstep = (f[0] ^ p[0]) | (f[1] ^ p[1]); // [R18]
            nup = (f[0] ^ p[0]) ? (f[0] ^ f[1]) : ~(f[0] ^ f[1]);
         end
         FMT_PDIR:
         begin
            nstep = a_e; // [R18]
            nup = f[1];
         end
         default:
         begin
            nstep = a_e ^ b_e; // [R18]
            nup = a_e;
         end
      endcase
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         p <= 2'h0;
         step_o <= 1'b0;
         up_o <= 1'b0;
      end
      else
      begin
         p <= f;
         step_o <= nstep;
         up_o <= nup ^ inv_i; // [R1]
      end
   end
endmodule // spc_cmd_in

// ==== spc_div_out.sv ====
// Divided quadrature output from feedback steps.
// Assumes at most one feedback count per clock.
`timescale 1ns/10ps
module spc_div_out (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Feedback steps and ratio
   input wire logic step_i,
   input wire logic up_i,
   input wire logic [31:0] add_i,
   input wire logic [31:0] thr_i,
   input wire logic inv_i,
   // Outputs
   output logic a_o,
   output logic b_o
);
   logic signed [34:0] acc, nacc, sadd, sthr;
   logic [1:0] q;
   assign sadd = 35'(add_i);
   assign sthr = 35'(thr_i);
   assign nacc = acc + (step_i ? (up_i ? sadd : -sadd) : 35'sh0);
   // One output edge per clock; fast motion lags behind
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acc <= 35'sh0;
         q <= 2'h0;
      end
      else if (nacc >= sthr)
      begin
         acc <= nacc - sthr; // [R12]
         q <= q + 2'h1;
      end
      else if (nacc <= -sthr)
      begin
         acc <= nacc + sthr; // [R12]
         q <= q - 2'h1;
      end
      else
         acc <= nacc;
   end
   // Gray code; swap channels to reverse sequence
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         a_o <= 1'b0;
         b_o <= 1'b0;
      end
      else
      begin
         a_o <= inv_i ? (q[1] ^ q[0]) : q[1]; // [R13]
         b_o <= inv_i ? q[1] : (q[1] ^ q[0]); // [R13]
      end
   end
endmodule // spc_div_out

// ==== spc_pos_cmd.sv ====
// Position command top: registers, gearing,
// smoothing, deviation checks and divided output.
// Assumes fb_pos_i and the Wishbone inputs are on clk_i; the command and drive state inputs are pins.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/10ps
module spc_pos_cmd
   import spc_pkg::*;
#(
   parameter int SMOOTH_TICK_CYC = SMOOTH_UNIT_CYC
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Command pulse pins
   input wire logic cmd_pa_i,
   input wire logic cmd_pb_i,
   // Drive state pins
   input wire logic overtravel_i,
   input wire logic servo_on_i,
   input wire logic gear_sel_i,
   // Feedback position
   input wire logic [31:0] fb_pos_i,
   // Status outputs
   output logic pos_done_o,
   output logic pos_near_o,
   output logic dev_alarm_o,
   output logic son_alarm_o,
   output logic dev_warn_o,
   output logic son_warn_o,
   output logic overshoot_o,
   // Divided encoder output
   output logic div_a_o,
   output logic div_b_o
);
   logic [31:0] cfg [NCFG];
   logic [2:0] ps1, ps2;
   logic acc_req, wr, ot, son, gsel;
   logic [4:0] idx;
   logic [31:0] wmask, st_word;
   logic [31:0] ctrl;
   logic cmd_step, cmd_up;
   logic [29:0] num, den;
   logic signed [34:0] rem, nrem, snum, sden;
   logic signed [31:0] target, smooth, dev, fb_prev;
   logic [31:0] absdev;
   logic [15:0] tick_cnt;
   logic [16:0] per_cnt, per_lim;
   logic tick, gear_idle, pulse_seen;
   logic [38:0] dev_x100, dev_lim_x, son_lim_x, ovs_x;
   logic done_ok, next_done, next_near, next_ald, next_als;
   logic next_wd, next_ws, next_ovs;
   logic [31:0] div_add, div_thr;

   assign ctrl = cfg[IDX_CTRL];
   assign idx = wb_adr_i[6:2];
   assign acc_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = acc_req & wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Pins pass two flops before use
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ps1 <= 3'h0;
         ps2 <= 3'h0;
      end
      else
      begin
         ps1 <= {gear_sel_i, servo_on_i, overtravel_i};
         ps2 <= ps1;
      end
   end
   assign ot = ps2[0];
   assign son = ps2[1];
   assign gsel = ps2[2] | ctrl[CTL_GEAR_SW]; // [R21]

   // Config registers, byte lanes, unused bits zero
   for (genvar i = 0; i < NCFG; i++)
   begin : g_cfg
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
            cfg[i] <= CFG_RST[i];
         else if (wr && !wb_adr_i[7] && idx == 5'(i))
            cfg[i] <= ((cfg[i] & ~wmask) | (wb_dat_i & wmask)) & CFG_MASK[i];
      end
   end

   // Ack one cycle after request; unmapped reads return zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= acc_req;
         if (acc_req && !wb_we_i)
         begin
            if (wb_adr_i[7])
               wb_dat_o <= 32'h0;
            else if (idx < 5'(NCFG))
               wb_dat_o <= cfg[idx];
            else if (idx == IDX_STATUS)
               wb_dat_o <= st_word;
            else if (idx == IDX_DEV)
               wb_dat_o <= dev;
            else
               wb_dat_o <= 32'h0;
         end
      end
   end
   assign st_word = {25'h0, overshoot_o, son_warn_o, dev_warn_o, son_alarm_o, dev_alarm_o,
      pos_near_o, pos_done_o};

   // Command pulse conditioning
   spc_cmd_in u_cmd_in (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pa_i(cmd_pa_i),
      .pb_i(cmd_pb_i),
      .fmt_i(ctrl[CTL_FMT_LSB +: 2]),
      .fall_i(ctrl[CTL_FALL]),
      .inv_i(ctrl[CTL_DIR_INV]),
      .width_i(cfg[IDX_FILT][10:0]),
      .step_o(cmd_step),
      .up_o(cmd_up)
   );

   // Active ratio: pulses per rev wins, else the selected gear pair
   always_comb
   begin
      if (cfg[IDX_PPR] != 32'h0)
      begin
         num = ENC_COUNTS[29:0]; // [R7]
         den = cfg[IDX_PPR][29:0];
      end
      else if (gsel)
      begin
         num = cfg[IDX_G2N][29:0]; // [R21]
         den = cfg[IDX_G2D][29:0];
      end
      else
      begin
         num = cfg[IDX_G1N][29:0]; // [R7]
         den = cfg[IDX_G1D][29:0];
      end
   end
   // A zero denominator would make target move every clock, so it acts as one
   assign snum = 35'(num);
   assign sden = (den == 30'h0) ? 35'sh1 : 35'(den);
   assign nrem = rem + (cmd_step ? (cmd_up ? snum : -snum) : 35'sh0); // [R20]
   assign gear_idle = (rem < sden) && (rem > -sden);

   // Gear scaling: remainder drains one scaled unit per clock
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rem <= 35'sh0;
         target <= 32'sh0;
      end
      else if (ot && ctrl[CTL_OT_CLR])
      begin
         rem <= 35'sh0; // [R19]
         target <= fb_pos_i;
      end
      else if (nrem >= sden)
      begin
         rem <= nrem - sden; // [R20]
         target <= target + 32'sh1;
      end
      else if (nrem <= -sden)
      begin
         rem <= nrem + sden; // [R20]
         target <= target - 32'sh1;
      end
      else
         rem <= nrem;
   end

   // Recent pulse flag; cleared each smoothing tick
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pulse_seen <= 1'b0;
      else if (cmd_step)
         pulse_seen <= 1'b1;
      else if (tick)
         pulse_seen <= 1'b0;
   end

   // 0.1 ms time base
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tick_cnt <= 16'h0;
      else if (tick)
         tick_cnt <= 16'h0;
      else
         tick_cnt <= tick_cnt + 16'h1;
   end
   assign tick = (tick_cnt >= 16'(SMOOTH_TICK_CYC - 1));

   // Smoothing: both time settings stretch the step period
   assign per_lim = 17'(cfg[IDX_MAVG][13:0]) + 17'(cfg[IDX_LPF][15:0]); // [R9] [R10]
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         per_cnt <= 17'h0;
         smooth <= 32'sh0;
      end
      else if (ot && ctrl[CTL_OT_CLR])
      begin
         per_cnt <= 17'h0;
         smooth <= fb_pos_i; // [R19]
      end
      else if (per_cnt >= per_lim)
      begin
         per_cnt <= 17'h0;
         if (smooth < target)
            smooth <= smooth + 32'sh1; // [R9]
         else if (smooth > target)
            smooth <= smooth - 32'sh1; // [R10]
      end
      else if (tick)
         per_cnt <= per_cnt + 17'h1;
   end

   // Deviation and its magnitude
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dev <= 32'sh0;
         fb_prev <= 32'sh0;
      end
      else
      begin
         dev <= smooth - fb_pos_i; // [R20]
         fb_prev <= fb_pos_i;
      end
   end
   assign absdev = dev[31] ? 32'(-dev) : 32'(dev);

   // Percent comparisons, scaled by 100 on the deviation side
   assign dev_x100 = 39'(absdev) * 39'd100;
   assign dev_lim_x = 39'(cfg[IDX_DEV_LIM]) * 39'(cfg[IDX_WARN_PCT]); // [R14]
   assign son_lim_x = 39'(cfg[IDX_SON_LIM]) * 39'(cfg[IDX_SON_PCT]); // [R16]
   assign ovs_x = 39'(cfg[IDX_DONE_WIN]) * 39'(cfg[IDX_OVS_PCT]); // [R17]

   // Done condition per mode
   always_comb
   begin
      case (ctrl[CTL_DONE_LSB +: 2])
         DONE_DEV: done_ok = 1'b1; // [R4]
         DONE_FILT: done_ok = (smooth == target) && !pulse_seen; // [R4]
         DONE_POST: done_ok = (smooth == target) && !pulse_seen && gear_idle; // [R4]
         default: done_ok = 1'b1;
      endcase
      next_done = (absdev < cfg[IDX_DONE_WIN]) && done_ok; // [R5]
      next_near = absdev < cfg[IDX_NEAR_WIN]; // [R6]
      next_ald = (cfg[IDX_DEV_LIM] != 32'h0) && (absdev > cfg[IDX_DEV_LIM]); // [R8]
      next_als = son && (cfg[IDX_SON_LIM] != 32'h0) && (absdev > cfg[IDX_SON_LIM]); // [R15]
      next_wd = (cfg[IDX_DEV_LIM] != 32'h0) && (dev_x100 > dev_lim_x); // [R14]
      next_ws = son && (cfg[IDX_SON_LIM] != 32'h0) && (dev_x100 > son_lim_x); // [R16]
      next_ovs = (smooth == target) && (dev_x100 > ovs_x); // [R17]
   end

   // Level status bits
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pos_done_o <= 1'b0;
         pos_near_o <= 1'b0;
         dev_warn_o <= 1'b0;
         son_warn_o <= 1'b0;
         overshoot_o <= 1'b0;
      end
      else
      begin
         pos_done_o <= next_done;
         pos_near_o <= next_near;
         dev_warn_o <= next_wd;
         son_warn_o <= next_ws;
         overshoot_o <= next_ovs;
      end
   end

   // Alarms latch; write one to clear, a new fault wins the clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dev_alarm_o <= 1'b0;
         son_alarm_o <= 1'b0;
      end
      else
      begin
         dev_alarm_o <= next_ald | (dev_alarm_o &
            ~(wr && idx == IDX_STATUS && !wb_adr_i[7] && wb_sel_i[0] && wb_dat_i[ST_ALM_DEV])); // [R8]
         son_alarm_o <= next_als | (son_alarm_o &
            ~(wr && idx == IDX_STATUS && !wb_adr_i[7] && wb_sel_i[0] && wb_dat_i[ST_ALM_SON])); // [R15]
      end
   end

   // Divided output ratio without a divider
   always_comb
   begin
      if (cfg[IDX_DIV_DEN] == 32'h0)
      begin
         div_add = {cfg[IDX_DIV_CNT][29:0], 2'b00}; // [R11]
         div_thr = ENC_COUNTS;
      end
      else
      begin
         div_add = cfg[IDX_DIV_CNT]; // [R11]
         div_thr = cfg[IDX_DIV_DEN];
      end
   end

   spc_div_out u_div_out (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .step_i(fb_pos_i != fb_prev),
      .up_i($signed(fb_pos_i - fb_prev) > 32'sh0),
      .add_i(div_add),
      .thr_i(div_thr),
      .inv_i(ctrl[CTL_PH_INV]),
      .a_o(div_a_o),
      .b_o(div_b_o)
   );
endmodule // spc_pos_cmd

// ==== spc_pos_cmd_sva.sv ====
// Checker: bus handshake, sticky alarms, divided output.
// Bound to spc_pos_cmd; sees only its ports.
`timescale 1ns/10ps
module spc_pos_cmd_sva (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Drive state and outputs
   input wire logic servo_on_i,
   input wire logic dev_alarm_o,
   input wire logic son_alarm_o,
   input wire logic div_a_o,
   input wire logic div_b_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Status write
   logic st_wr;
   assign st_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h48 && wb_sel_i[0];
   // Request and read kinds
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rd_unmapped;
      s_req ##0 (!wb_we_i && wb_adr_i[7]);
   endsequence
   sequence s_rd_divcnt;
      s_req ##0 (!wb_we_i && wb_adr_i == 8'h24);
   endsequence
   property p_ack_next;
      s_req |=> wb_ack_o;
   endproperty
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   property p_unmapped;
      s_rd_unmapped |=> wb_dat_o == 32'h0;
   endproperty
   property p_divcnt_width;
      s_rd_divcnt |=> wb_dat_o[31:16] == 16'h0;
   endproperty
   property p_dev_sticky;
      $fell(dev_alarm_o) |-> $past(st_wr && wb_dat_i[2]) || $past(st_wr && wb_dat_i[2], 2);
   endproperty
   property p_son_sticky;
      $fell(son_alarm_o) |-> $past(st_wr && wb_dat_i[3]) || $past(st_wr && wb_dat_i[3], 2);
   endproperty
   property p_son_cause;
      $rose(son_alarm_o) |-> $past(servo_on_i) || $past(servo_on_i, 2) || $past(servo_on_i, 3);
   endproperty
   property p_gray;
      !($changed(div_a_o) && $changed(div_b_o));
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
   a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_divcnt_width: assert property (p_divcnt_width) else $error("pulse count reads wide");
   a_dev_sticky: assert property (p_dev_sticky) else $error("deviation alarm fell alone");
   a_son_sticky: assert property (p_son_sticky) else $error("servo-on alarm fell alone");
   a_son_cause: assert property (p_son_cause) else $error("servo-on alarm while off");
   a_gray: assert property (p_gray) else $error("both divided phases moved");
endmodule // spc_pos_cmd_sva

bind spc_pos_cmd spc_pos_cmd_sva spc_pos_cmd_sva_inst (.*);

// ==== spc_host_model.sv ====
// Host model: one command count per step, chosen format.
// fmt_i steady during steps; park only under reset.
`timescale 1ns/10ps
module spc_host_model #(
   parameter int HOLD = 6
)
(
   // Clock and format
   input wire logic clk_i,
   input wire logic [1:0] fmt_i,
   // Pins
   output logic pa_o = 1'b0,
   output logic pb_o = 1'b0
);
   logic [1:0] q = 2'h0;
   task automatic hold_n;
      repeat (HOLD) @(posedge clk_i);
   endtask
   // Idle low, phase zero
   task automatic park;
      q = 2'h0;
      pa_o <= 1'b0;
      pb_o <= 1'b0;
   endtask
   // Each level held HOLD cycles so the filter can pass it
   task automatic step(input logic up);
      if (fmt_i == 2'h0)
      begin
         q = up ? q + 2'h1 : q - 2'h1;
         pa_o <= q[1];
         pb_o <= q[1] ^ q[0];
      end
      else if (fmt_i == 2'h1)
      begin
         pb_o <= up;
         hold_n();
         pa_o <= 1'b1;
         hold_n();
         pa_o <= 1'b0;
      end
      else
      begin
         if (up)
            pa_o <= 1'b1;
         else
            pb_o <= 1'b1;
         hold_n();
         pa_o <= 1'b0;
         pb_o <= 1'b0;
      end
      hold_n();
   endtask
endmodule // spc_host_model

// ==== spc_pos_cmd_tb.sv ====
// Bench for the position command logic.
// Needs the host model and the bound checker; one 100 MHz clock.
`timescale 1ns/10ps
module spc_pos_cmd_tb;
   import spc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, fb_pos_i = 32'h0, rdat, seed = 32'h7f40, wb_dat_o;
   logic overtravel_i = 1'b0, servo_on_i = 1'b0, gear_sel_i = 1'b0;
   logic wb_ack_o, cmd_pa_i, cmd_pb_i, pos_done_o, pos_near_o, dev_alarm_o, son_alarm_o;
   logic dev_warn_o, son_warn_o, overshoot_o, div_a_o, div_b_o, first_a;
   logic [1:0] fmt = 2'h0;
   int failures = 0, n_tests = 0, cyc = 0, na = 0, nb = 0;
   localparam logic [31:0] CTAB [6] = '{32'h0, 32'h1, 32'h11, 32'h2, 32'h3, 32'h9};
   initial forever #5 clk_i = ~clk_i;
   spc_pos_cmd #(.SMOOTH_TICK_CYC(4)) spc_pos_cmd_inst (.*);
   spc_host_model spc_host_model_inst (.clk_i, .fmt_i(fmt), .pa_o(cmd_pa_i), .pb_o(cmd_pb_i));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Hold until ack sampled, then idle a cycle
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) failures++;
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic reset_dut;
      rst_i <= 1'b1;
      fb_pos_i <= 32'h0;
      servo_on_i <= 1'b0;
      overtravel_i <= 1'b0;
      gear_sel_i <= 1'b0;
      spc_host_model_inst.park();
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic steps(input int n, input logic [31:0] exp);
      repeat (n) spc_host_model_inst.step(1'b1);
      repeat (40) @(posedge clk_i);
      bus(1'b0, 8'h4c, 32'h0);
      check("deviation", rdat, exp);
   endtask
   // Divided output toggles and lead
   always @(div_a_o)
   begin
      if (na + nb == 0) first_a = 1'b1;
      na++;
   end
   always @(div_b_o)
   begin
      if (na + nb == 0) first_a = 1'b0;
      nb++;
   end
   // Hang guard above run length
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         failures++;
         wrap_up();
      end
   end
   initial
   begin
      reset_dut();
      for (int i = 0; i < NCFG; i++)
      begin
         bus(1'b0, 8'(i * 4), 32'h0);
         check("reset value", rdat, CFG_RST[i]);
         seed = lfsr(seed);
         bus(1'b1, 8'(i * 4), seed);
         bus(1'b0, 8'(i * 4), 32'h0);
         check("readback", rdat, seed & CFG_MASK[i]);
      end
      bus(1'b1, 8'h80, seed);
      bus(1'b0, 8'h80, 32'h0);
      check("unmapped", rdat, 32'h0);
      // Every format, both edges, inverted direction: net two counts
      foreach (CTAB[k])
      begin
         reset_dut();
         fmt = CTAB[k][1:0];
         bus(1'b1, 8'h00, CTAB[k]);
         repeat (3) spc_host_model_inst.step(1'b1);
         spc_host_model_inst.step(1'b0);
         repeat (40) @(posedge clk_i);
         bus(1'b0, 8'h4c, 32'h0);
         if (k == 0 && rdat[31]) rdat = -rdat;
         check("format count", rdat, CTAB[k][3] ? -32'sd2 : 32'd2);
      end
      // Short pulses refused by the filter, then gearing
      reset_dut();
      fmt = 2'h1;
      bus(1'b1, 8'h00, 32'h1);
      bus(1'b1, 8'h04, 32'h1);
      steps(1, 32'h0);
      bus(1'b1, 8'h04, 32'h0);
      steps(1, 32'h1);
      bus(1'b1, 8'h10, 32'h0040_0000);
      steps(1, 32'h3);
      bus(1'b1, 8'h10, 32'h0);
      bus(1'b1, 8'h38, 32'h3);
      steps(1, 32'h6);
      gear_sel_i <= 1'b1;
      bus(1'b1, 8'h40, 32'h5);
      steps(1, 32'hb);
      // Thresholds against a deviation of 11
      bus(1'b1, 8'h14, 32'h8);
      bus(1'b1, 8'h28, 32'd50);
      bus(1'b1, 8'h08, 32'd12);
      bus(1'b1, 8'h0c, 32'h4);
      bus(1'b1, 8'h34, 32'd50);
      bus(1'b1, 8'h2c, 32'ha);
      bus(1'b1, 8'h30, 32'd100);
      repeat (10) @(posedge clk_i);
      check("alarm", dev_alarm_o, 1'b1);
      check("warning", dev_warn_o, 1'b1);
      check("done", pos_done_o, 1'b1);
      check("near", pos_near_o, 1'b0);
      check("overshoot", overshoot_o, 1'b1);
      check("son alarm off", son_alarm_o, 1'b0);
      servo_on_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      check("son alarm", son_alarm_o, 1'b1);
      check("son warning", son_warn_o, 1'b1);
      fb_pos_i <= 32'hb;
      repeat (10) @(posedge clk_i);
      check("warn gone", {dev_warn_o, son_warn_o, pos_near_o}, 3'h1);
      check("alarm kept", dev_alarm_o, 1'b1);
      servo_on_i <= 1'b0;
      bus(1'b1, 8'h48, 32'hc);
      repeat (4) @(posedge clk_i);
      check("alarm clear", {dev_alarm_o, son_alarm_o}, 2'h0);
      // Overtravel keeps or clears the residue
      bus(1'b1, 8'h14, 32'h0);
      fb_pos_i <= 32'h0;
      overtravel_i <= 1'b1;
      steps(0, 32'hb);
      bus(1'b1, 8'h00, 32'h5);
      steps(0, 32'h0);
      overtravel_i <= 1'b0;
      // Done mode 1 waits for the averaged command to settle
      bus(1'b1, 8'h00, 32'h21);
      bus(1'b1, 8'h18, 32'ha);
      spc_host_model_inst.step(1'b1);
      check("done early", pos_done_o, 1'b0);
      repeat (400) @(posedge clk_i);
      check("done settled", pos_done_o, 1'b1);
      // Divided output, ratio one per two counts, both phase orders
      for (int inv = 0; inv < 2; inv++)
      begin
         reset_dut();
         bus(1'b1, 8'h00, 32'(inv) << 7);
         bus(1'b1, 8'h20, 32'h2);
         bus(1'b1, 8'h24, 32'h1);
         na = 0;
         nb = 0;
         repeat (64)
         begin
            fb_pos_i <= fb_pos_i + 32'h1;
            @(posedge clk_i);
         end
         repeat (10) @(posedge clk_i);
         check("a toggles", 32'(na), 32'd16);
         check("b toggles", 32'(nb), 32'd16);
         check("lead phase", {31'h0, first_a}, 32'(inv));
      end
      wrap_up();
   end
endmodule // spc_pos_cmd_tb
